// ==== hdl/fetch_pipeline.sv ====
// Purpose: phase sequencing, two-stage fetch/execute pipeline, shadow context
// Assumes: program memory answers pmem_addr_q combinationally on pmem_rd_data
// Notes:   flow commands are sampled at the phase four edge of an execute cycle
`timescale 1ns/1ns
`include "fetch_params.svh"

module fetch_pipeline #(
   parameter int PC_W = `PC_W,
   parameter int IR_W = `IR_W
) (
   // clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   rst_n,
   // program memory
   output logic [PC_W-1:0]             pmem_addr_q,
   input  wire logic [IR_W-1:0]        pmem_rd_data,
   // execute side controls
   input  wire fetch_pkg::exec_cmd_s   exec_cmd,
   input  wire logic                   irq_take,
   input  wire logic [PC_W-1:0]        irq_vector,
   input  wire fetch_pkg::ctx_wr_s     ctx_wr,
   input  wire logic [`BYTE_W-1:0]     pc_high_latch,
   input  wire logic [`BYTE_W-1:0]     pc_upper_latch,
   // table read
   input  wire logic                   table_rd_req,
   input  wire logic [PC_W-1:0]        table_pointer,
   output logic [`BYTE_W-1:0]          table_latch_q,
   // pipeline state
   output fetch_pkg::phase_e           phase_q,
   output logic [PC_W-1:0]             pc_q,
   output logic [IR_W-1:0]             ir_q,
   output logic                        ir_valid_q,
   output logic                        dmem_rd_q,
   output logic                        dmem_wr_q,
   output logic                        push_q,
   output logic [PC_W-1:0]             push_addr_q,
   output fetch_pkg::ctx_s             live_q
);
   import fetch_pkg::*;

   logic [1:0]       rst_sync_q;
   logic             rst_int_n;
   logic [PC_W-1:0]  fetch_addr_q;
   logic             table_busy_q;
   ctx_s             shadow_q;
   logic             take_cmd;
   logic             take_irq;
   logic             pc_change;
   logic [PC_W-1:0]  pc_target;
   // low pc byte as written by a computed jump
   logic [`BYTE_W-1:0] low_new;
   logic             do_save;
   logic             do_restore;

   // reset released through two flops
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_int_n = rst_sync_q[1];

   // quadrature phase divider
   phase_gen u_phase (
      .sys_clk (sys_clk),
      .rst_n   (rst_int_n),
      .phase_q (phase_q)
   );

   // flow decisions are made at the end of phase four
   assign take_irq  = (phase_q == PH_FOUR) && irq_take;
   assign take_cmd  = (phase_q == PH_FOUR) && ir_valid_q && !irq_take;
   // only the fast option touches the shadow on calls and returns
   assign do_save   = take_irq || (take_cmd && exec_cmd.op == OP_CALL && exec_cmd.fast);
   assign do_restore = take_cmd && exec_cmd.fast &&
                       (exec_cmd.op == OP_RETURN || exec_cmd.op == OP_RET_INT);

   // new pc for each flow operation; the low bit is forced to zero except on a branch, where it comes from pc
   always_comb begin
      pc_change = 1'b1;
      low_new   = exec_cmd.low_data;
      pc_target = pc_q;
      if (take_irq) begin
         pc_target = {irq_vector[PC_W-1:1], 1'b0};
      end else if (take_cmd) begin
         case (exec_cmd.op)
            OP_GOTO, OP_CALL: begin
               pc_target = {exec_cmd.word_target, 1'b0};
            end
            OP_BRANCH: begin
               pc_target = pc_q + PC_W'({{(PC_W-`OFS_W){exec_cmd.offset[`OFS_W-1]}},
                                          exec_cmd.offset} << 1);
            end
            OP_RETURN, OP_RET_INT: begin
               pc_target = {exec_cmd.ret_addr[PC_W-1:1], 1'b0};
            end
            OP_ADD_W_LOW: begin
               low_new   = pc_q[`BYTE_W-1:0] + live_q.working;
               pc_target = PC_W'({pc_upper_latch, pc_high_latch,
                                  low_new[`BYTE_W-1:1], 1'b0});
            end
            OP_WRITE_LOW: begin
               pc_target = PC_W'({pc_upper_latch, pc_high_latch,
                                  low_new[`BYTE_W-1:1], 1'b0});
            end
            default: begin
               pc_change = 1'b0;
            end
         endcase
      end else begin
         pc_change = 1'b0;
      end
   end

   // pc: step in phase one, reload at the end of execute
   always_ff @(posedge sys_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         pc_q         <= `RESET_VECTOR;
         fetch_addr_q <= `RESET_VECTOR;
      end else if (phase_q == PH_ONE) begin
         fetch_addr_q <= pc_q;
         pc_q         <= pc_q + `PC_STEP;
      end else if (pc_change) begin
         pc_q <= pc_target;
      end
   end

   // memory address: table access borrows phase two, fetch holds the rest
   always_ff @(posedge sys_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         pmem_addr_q  <= `RESET_VECTOR;
         table_busy_q <= 1'b0;
      end else if (phase_q == PH_ONE) begin
         table_busy_q <= table_rd_req;
         pmem_addr_q  <= table_rd_req ? {table_pointer[PC_W-1:1], 1'b0} : pc_q;
      end else if (phase_q == PH_TWO) begin
         table_busy_q <= 1'b0;
         pmem_addr_q  <= fetch_addr_q;
      end
   end

   // one byte per transfer, odd pointer picks the high byte
   always_ff @(posedge sys_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         table_latch_q <= 8'h00;
      end else if (phase_q == PH_TWO && table_busy_q) begin
         table_latch_q <= table_pointer[0] ? pmem_rd_data[IR_W-1:`BYTE_W]
                                           : pmem_rd_data[`BYTE_W-1:0];
      end
   end

   // instruction register; the prefetch is marked dead after a flow change
   always_ff @(posedge sys_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         ir_q       <= '0;
         ir_valid_q <= 1'b0;
      end else if (phase_q == PH_FOUR) begin
         ir_q       <= pmem_rd_data;
         ir_valid_q <= !pc_change;
      end
   end

   // data memory strobes, registered so they sit inside their phase
   always_ff @(posedge sys_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         dmem_rd_q <= 1'b0;
         dmem_wr_q <= 1'b0;
      end else begin
         dmem_rd_q <= (phase_q == PH_ONE) && ir_valid_q;
         dmem_wr_q <= (phase_q == PH_THREE) && ir_valid_q;
      end
   end

   // return address push toward the external stack
   always_ff @(posedge sys_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         push_q      <= 1'b0;
         push_addr_q <= `RESET_VECTOR;
      end else begin
         push_q <= take_irq || (take_cmd && exec_cmd.op == OP_CALL);
         if (take_irq || (take_cmd && exec_cmd.op == OP_CALL)) begin
            push_addr_q <= pc_q;
         end
      end
   end

   // shadow copy, reachable only by vectoring and fast call
   always_ff @(posedge sys_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         shadow_q <= '{`STATUS_RST, `WORK_RST, `BANK_RST};
      end else if (do_save) begin
         shadow_q <= live_q;
      end
   end

   // live context; a fast return wins over an ordinary write in the same cycle
   always_ff @(posedge sys_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         live_q <= '{`STATUS_RST, `WORK_RST, `BANK_RST};
      end else if (do_restore) begin
         live_q <= shadow_q;
      end else if (phase_q == PH_FOUR) begin
         if (ctx_wr.status_we)      live_q.status      <= ctx_wr.data.status;
         if (ctx_wr.working_we)     live_q.working     <= ctx_wr.data.working;
         if (ctx_wr.bank_select_we) live_q.bank_select <= ctx_wr.data.bank_select;
      end
   end

   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_int_n);

   a_phase_onehot: assert property ($onehot(phase_q))
      else $error("phase is not one-hot");
   a_phase_order: assert property (phase_q == PH_ONE |=> phase_q == PH_TWO
                                   ##1 phase_q == PH_THREE ##1 phase_q == PH_FOUR)
      else $error("phases out of order");
   a_pc_step: assert property (phase_q == PH_ONE |=> pc_q == $past(pc_q) + `PC_STEP)
      else $error("pc did not step by two in phase one");
   a_pc_even: assert property (!pc_q[0] && !pmem_addr_q[0])
      else $error("odd program address");
   a_flush_two: assert property (pc_change |=> !ir_valid_q ##4 ir_valid_q || irq_take)
      else $error("prefetch not discarded after flow change");
   a_irq_shadow: assert property (take_irq |=> shadow_q == $past(live_q))
      else $error("shadow not captured on interrupt");
   a_fast_restore: assert property (do_restore |=> live_q == $past(shadow_q))
      else $error("fast return did not restore context");
   a_plain_keep: assert property (take_cmd && !exec_cmd.fast &&
                                  exec_cmd.op inside {OP_CALL, OP_RETURN, OP_RET_INT}
                                  |=> $stable(shadow_q))
      else $error("shadow changed without fast option");
   a_abs_target: assert property (take_cmd && exec_cmd.op == OP_GOTO
                                  |=> pc_q == {$past(exec_cmd.word_target), 1'b0})
      else $error("absolute target not loaded");
   a_dmem_phase: assert property ((dmem_rd_q |-> phase_q == PH_TWO) and
                                  (dmem_wr_q |-> phase_q == PH_FOUR))
      else $error("data strobe in wrong phase");

   // operand read only belongs to a live instruction
   a_dmem_valid: assert property (dmem_rd_q |-> ir_valid_q)
      else $error("read strobe without a live instruction");
   // the shadow moves only on a save event
   a_shadow_quiet: assert property (!do_save |=> $stable(shadow_q))
      else $error("shadow changed without a save");
   // outside phase four only a fast return may move the live registers
   a_live_hold: assert property (!do_restore && phase_q != PH_FOUR |=> $stable(live_q))
      else $error("live context changed outside phase four");
   // the instruction register loads in phase four only
   a_ir_phase: assert property (phase_q != PH_FOUR |=> $stable(ir_q))
      else $error("instruction register loaded outside phase four");
   // pc stands still through phases two and three
   a_pc_hold: assert property (phase_q inside {PH_TWO, PH_THREE} |=> $stable(pc_q))
      else $error("pc moved in phase two or three");
   // memory goes back to the fetch address once a table read is done
   a_fetch_back: assert property (phase_q == PH_THREE |-> pmem_addr_q == fetch_addr_q)
      else $error("fetch address not restored after phase two");
   // a push lasts one clock only
   a_push_once: assert property (push_q |=> !push_q)
      else $error("push held longer than one clock");
   // vectoring pushes the pc that was current
   a_irq_push: assert property (take_irq |=> push_q && push_addr_q == $past(pc_q))
      else $error("interrupt did not push the pc");
   // every call pushes, fast or not
   a_call_push: assert property (take_cmd && exec_cmd.op == OP_CALL |=> push_q)
      else $error("call did not push");
   // a low byte write brings the high latch into pc bits 15:8
   a_write_low: assert property (take_cmd && exec_cmd.op == OP_WRITE_LOW
                                 |=> pc_q[2*`BYTE_W-1:`BYTE_W] == $past(pc_high_latch))
      else $error("high latch not merged into pc");

   // main scenarios

   c_branch: cover property (take_cmd && exec_cmd.op == OP_BRANCH);
   c_irq_nested: cover property (take_irq ##[4:40] take_irq);
   c_table_read: cover property (phase_q == PH_TWO && table_busy_q);
   c_fast_ret: cover property (do_restore);
   c_fast_call: cover property (take_cmd && exec_cmd.op == OP_CALL && exec_cmd.fast);

endmodule : fetch_pipeline

// ==== hdl/fetch_params.svh ====
// Purpose: named constants of the fetch and execute sequencer
// Assumes: included by the package and the design modules
// Notes:   definitions only
`ifndef FETCH_PARAMS_SVH
`define FETCH_PARAMS_SVH

`define PC_W          21
`define IR_W          16
`define BYTE_W        8
`define BANK_W        4
`define OFS_W         11
`define PC_STEP       21'h000002
`define RESET_VECTOR  21'h000000
`define STATUS_RST    8'h00
`define WORK_RST      8'h00
`define BANK_RST      4'h0
`define PHASE_CNT     4

`endif

// ==== hdl/fetch_pkg.sv ====
// Purpose: types shared by the sequencer modules
// Assumes: fetch_params.svh supplies the widths
// Notes:   phase codes are one-hot
`include "fetch_params.svh"

package fetch_pkg;

   // one bit per quadrature phase
   typedef enum logic [3:0] {
      PH_ONE   = 4'b0001,
      PH_TWO   = 4'b0010,
      PH_THREE = 4'b0100,
      PH_FOUR  = 4'b1000
   } phase_e;

   // program flow operation of the instruction in execute
   typedef enum logic [2:0] {
      OP_SEQ       = 3'h0,
      OP_GOTO      = 3'h1,
      OP_BRANCH    = 3'h2,
      OP_CALL      = 3'h3,
      OP_RETURN    = 3'h4,
      OP_RET_INT   = 3'h5,
      OP_ADD_W_LOW = 3'h6,
      OP_WRITE_LOW = 3'h7
   } op_e;

   typedef struct packed {
      op_e                       op;
      logic                      fast;
      logic [`PC_W-2:0]          word_target;
      logic signed [`OFS_W-1:0]  offset;
      logic [`BYTE_W-1:0]        low_data;
      logic [`PC_W-1:0]          ret_addr;
   } exec_cmd_s;

   // status, working and bank select as one context
   typedef struct packed {
      logic [`BYTE_W-1:0] status;
      logic [`BYTE_W-1:0] working;
      logic [`BANK_W-1:0] bank_select;
   } ctx_s;

   typedef struct packed {
      logic               status_we;
      logic               working_we;
      logic               bank_select_we;
      ctx_s               data;
   } ctx_wr_s;

endpackage : fetch_pkg

// ==== hdl/phase_gen.sv ====
// Purpose: divides the clock into four rotating one-hot phases
// Assumes: rst_n is already synchronised
// Notes:   phase one follows reset release
`timescale 1ns/1ns
`include "fetch_params.svh"

module phase_gen (
   // clock and reset
   input  wire logic            sys_clk,
   input  wire logic            rst_n,
   // current phase
   output fetch_pkg::phase_e    phase_q
);
   import fetch_pkg::*;

   // rotate through the four phases, one per clock
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_q <= PH_ONE;
      end else begin
         case (phase_q)
            PH_ONE:   phase_q <= PH_TWO;
            PH_TWO:   phase_q <= PH_THREE;
            PH_THREE: phase_q <= PH_FOUR;
            PH_FOUR:  phase_q <= PH_ONE;
            default:  phase_q <= PH_ONE; // recover from a corrupted code
         endcase
      end
   end

endmodule : phase_gen

// ==== dv/pmem_model.sv ====
// Purpose: behavioural program memory at the far side of the sequencer
// Assumes: combinational read of the word at an even byte address
// Notes:   contents are a fixed pattern of the address so reads are predictable
`timescale 1ns/1ns

module pmem_model (
   // fetch address
   input  wire logic [20:0] addr,
   // instruction word
   output logic      [15:0] rd_data
);
   // bit zero is dropped: a word always starts at an even byte address
   always_comb begin
      rd_data = {addr[8:1] ^ 8'hc3, addr[16:9] ^ addr[8:1]};
   end
endmodule : pmem_model

// ==== dv/cpu_fetch_pipeline_fast_shadow_bench.sv ====
// Purpose: self-checking bench of the fetch pipeline and shadow context
// Assumes: commands taken at the phase four edge, one per instruction cycle
// Notes:   shadow capture cycles carry no register writes, as their order is open
`timescale 1ns/1ns

module cpu_fetch_pipeline_fast_shadow_bench;
   import fetch_pkg::*;

   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [20:0] pmem_addr_q, pc_q, push_addr_q;
   logic [15:0] pmem_rd_data, ir_q;
   exec_cmd_s   exec_cmd = '0;
   ctx_wr_s     ctx_wr = '0;
   logic        irq_take = 1'b0;
   logic [20:0] irq_vector = '0;
   logic [20:0] table_pointer = '0;
   logic [7:0]  pc_high_latch = '0;
   logic [7:0]  pc_upper_latch = '0;
   logic        table_rd_req = 1'b0;
   logic [7:0]  table_latch_q;
   phase_e      phase_q;
   logic        ir_valid_q, dmem_rd_q, dmem_wr_q, push_q;
   ctx_s        live_q;
   // reference state
   logic [20:0] pc_m = 21'h2;
   logic        valid_m = 1'b0;
   logic        do_tbl = 1'b0;
   ctx_s        live_m = '0;
   ctx_s        shad_m = '0;
   int          n_errors = 0;
   int          checked = 0;

   always #10 sys_clk = ~sys_clk;

   pmem_model u_pmem (.addr(pmem_addr_q), .rd_data(pmem_rd_data));

   fetch_pipeline u_dut (.sys_clk, .rst_n, .pmem_addr_q, .pmem_rd_data, .exec_cmd,
      .irq_take, .irq_vector, .ctx_wr, .pc_high_latch, .pc_upper_latch, .table_rd_req,
      .table_pointer, .table_latch_q, .phase_q, .pc_q, .ir_q, .ir_valid_q, .dmem_rd_q,
      .dmem_wr_q, .push_q, .push_addr_q, .live_q);

   task automatic end_sim();
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : chk

   function automatic logic [15:0] word_at(input logic [20:0] a);
      return {a[8:1] ^ 8'hc3, a[16:9] ^ a[8:1]};
   endfunction : word_at

   // one instruction cycle from the phase four sample point to the next
   task automatic cyc();
      logic [20:0] pc_n;
      logic [15:0] tw;
      logic [7:0]  sum;
      logic        flow, push, taken;
      op_e         op;
      int          k;
      op = exec_cmd.op;
      taken = valid_m && !irq_take;
      pc_n = pc_m;
      sum = pc_m[7:0] + live_m.working;
      tw = word_at(table_pointer);
      chk(phase_q, PH_FOUR, "phase at command");
      chk(pc_q, pc_m, "pc at phase four");
      chk(pmem_addr_q, pc_m - 21'h2, "fetch address");
      chk(dmem_wr_q, valid_m, "write strobe");
      // an interrupt wins over the command in execute
      if (irq_take) begin
         shad_m = live_m;
         pc_n = irq_vector & ~21'h1;
      end else if (taken) begin
         case (op)
            OP_GOTO, OP_CALL: pc_n = {exec_cmd.word_target, 1'b0};
            OP_BRANCH: pc_n = pc_m + 21'(2 * exec_cmd.offset);
            OP_RETURN, OP_RET_INT: pc_n = exec_cmd.ret_addr;
            OP_ADD_W_LOW: pc_n = {pc_upper_latch[4:0], pc_high_latch, sum[7:1], 1'b0};
            OP_WRITE_LOW: pc_n = {pc_upper_latch[4:0], pc_high_latch,
                                  exec_cmd.low_data[7:1], 1'b0};
            default: ;
         endcase
         if (op == OP_CALL && exec_cmd.fast) shad_m = live_m;
      end
      flow = irq_take || (taken && op != OP_SEQ);
      push = irq_take || (taken && op == OP_CALL);
      if (ctx_wr.status_we) live_m.status = ctx_wr.data.status;
      if (ctx_wr.working_we) live_m.working = ctx_wr.data.working;
      if (ctx_wr.bank_select_we) live_m.bank_select = ctx_wr.data.bank_select;
      // fast returns override the same-cycle register writes
      if (taken && exec_cmd.fast && (op == OP_RETURN || op == OP_RET_INT)) live_m = shad_m;
      @(posedge sys_clk);
      #2;
      chk(pc_q, pc_n, "pc after command");
      chk(live_q, live_m, "live context");
      chk(ir_valid_q, !flow, "slot validity");
      if (!flow) chk(ir_q, word_at(pc_m - 21'h2), "instruction");
      chk(push_q, push, "push pulse");
      if (push) chk(push_addr_q, pc_m, "return address");
      valid_m = !flow;
      pc_m = pc_n + 21'h2;
      // remaining phases, with the optional table read in phase two
      for (k = 0; k < 3; k++) begin
         chk(phase_q, 4'b0001 << k, "phase order");
         if (k == 0) table_rd_req = do_tbl;
         if (k == 1) begin
            table_rd_req = 1'b0;
            chk(dmem_rd_q, valid_m, "read strobe");
            if (do_tbl) chk(pmem_addr_q, table_pointer & ~21'h1, "table addr");
         end
         if (k == 2 && do_tbl) chk(table_latch_q, table_pointer[0] ? tw[15:8] : tw[7:0],
                                   "table byte");
         @(posedge sys_clk);
         #2;
      end
   endtask : cyc

   // random operands, then the cycle; no writes where the shadow or working is read
   task automatic go(input op_e op, input logic fast, input logic irq, input logic tbl);
      exec_cmd = {$urandom, $urandom};
      exec_cmd.op = op;
      exec_cmd.fast = fast;
      exec_cmd.ret_addr[0] = 1'b0;
      if (op == OP_CALL) exec_cmd.ret_addr = pc_m;
      irq_take = irq;
      irq_vector = 21'($urandom);
      ctx_wr = 23'($urandom);
      ctx_wr.data.working[0] = 1'b0;
      if (irq || fast || op == OP_ADD_W_LOW) ctx_wr[22:20] = 3'b0;
      {pc_upper_latch, pc_high_latch} = 16'($urandom);
      if (op == OP_ADD_W_LOW) {pc_upper_latch, pc_high_latch} = {3'b0, pc_m[20:8]};
      table_pointer = 21'($urandom);
      do_tbl = tbl;
      cyc();
   endtask : go

   // main sequence
   initial begin
      int i;
      repeat (3) @(posedge sys_clk);
      #2;
      rst_n = 1'b1;
      void'($urandom(95));
      for (i = 0; i < 12 && phase_q !== PH_FOUR; i++) begin
         @(posedge sys_clk);
         #2;
      end
      if (phase_q !== PH_FOUR) begin
         n_errors++;
         end_sim();
      end
      go(OP_GOTO, 1'b0, 1'b0, 1'b1);   // no instruction yet: refused
      go(OP_SEQ, 1'b0, 1'b0, 1'b1);
      go(OP_CALL, 1'b1, 1'b0, 1'b0);
      go(OP_GOTO, 1'b0, 1'b0, 1'b0);   // flushed slot: refused
      go(OP_SEQ, 1'b0, 1'b0, 1'b0);
      go(OP_RETURN, 1'b1, 1'b0, 1'b0);
      go(OP_SEQ, 1'b0, 1'b0, 1'b0);
      go(OP_CALL, 1'b0, 1'b0, 1'b0);
      go(OP_SEQ, 1'b0, 1'b0, 1'b0);
      go(OP_RETURN, 1'b0, 1'b0, 1'b0);
      go(OP_SEQ, 1'b0, 1'b0, 1'b0);
      go(OP_GOTO, 1'b0, 1'b1, 1'b0);   // interrupt beats the command
      go(OP_SEQ, 1'b0, 1'b0, 1'b0);
      go(OP_SEQ, 1'b0, 1'b0, 1'b0);
      go(OP_SEQ, 1'b0, 1'b1, 1'b0);    // nested entry overwrites the shadow
      go(OP_SEQ, 1'b0, 1'b0, 1'b0);
      go(OP_SEQ, 1'b0, 1'b0, 1'b0);
      go(OP_RET_INT, 1'b1, 1'b0, 1'b0);
      for (i = 1; i < 8; i++) begin
         go(OP_SEQ, 1'b0, 1'b0, 1'b0);
         go(op_e'(i), 1'b0, 1'b0, 1'b0);
      end
      for (i = 0; i < 80; i++) begin
         go(op_e'($urandom_range(0, 7)), 1'($urandom),
            valid_m && ($urandom_range(0, 5) == 0), 1'($urandom));
      end
      end_sim();
   end
endmodule : cpu_fetch_pipeline_fast_shadow_bench
